/* File: core/wait_state_pkg.sv */
`default_nettype none
package wait_state_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] WAIT_CYCLE_REG_ONE_ADDR = 8'h00;
   localparam logic [7:0] WAIT_CYCLE_REG_TWO_ADDR = 8'h04;
   localparam logic [7:0] BLOCK_BOUNDARY_REG_ADDR = 8'h08;
   localparam logic [7:0] REFRESH_CONTROL_REG_ADDR = 8'h0c;
   localparam logic [7:0] STATUS_REG_ADDR = 8'h10;
   // ==========================================================
   // Field positions, two bits per count
   localparam int LOWER_WAIT_POS = 0;
   localparam int MIDDLE_WAIT_POS = 2;
   localparam int UPPER_WAIT_POS = 4;
   localparam int IO_WAIT_POS = 0;
   localparam int DMA_WAIT_POS = 2;
   localparam int LOWER_SIZE_POS = 0;
   localparam int UPPER_SIZE_POS = 4;
   localparam int REFRESH_WAIT_POS = 0;
   localparam int STATUS_COUNT_POS = 0;
   localparam int STATUS_BUSY_POS = 2;
   localparam int WAIT_WIDTH = 2;
   localparam int SIZE_WIDTH = 3;
   // ==========================================================
   // Reset values: slowest timing, largest blocks
   localparam logic [1:0] WAIT_RESET = 2'h3;
   localparam logic [2:0] SIZE_RESET = 3'h7;
   // Size codes 0..7 = 32,64,96,128,192,256,384,512 KB, in 32 KB units
   localparam logic [4:0] SIZE_UNITS [8] = '{5'h01, 5'h02, 5'h03, 5'h04,
                                             5'h06, 5'h08, 5'h0c, 5'h10};
   localparam int UNIT_SHIFT = 15;
   // Cycle kinds
   typedef enum logic [1:0] {
      CYC_MEMORY = 2'b00,
      CYC_IO = 2'b01,
      CYC_DMA = 2'b10,
      CYC_REFRESH = 2'b11
   } cycle_kind_t;
   typedef enum logic [1:0] {
      BLK_LOWER = 2'b00,
      BLK_MIDDLE = 2'b01,
      BLK_UPPER = 2'b10
   } block_t;
endpackage : wait_state_pkg
`default_nettype wire

/* File: core/wait_config_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Bundle of programmed settings from register file to classifier
interface wait_config_if;
   logic [1:0] lower_block_wait_count;
   logic [1:0] middle_block_wait_count;
   logic [1:0] upper_block_wait_count;
   logic [1:0] io_cycle_wait_count;
   logic [1:0] dma_cycle_wait_count;
   logic [1:0] refresh_cycle_wait_count;
   logic [2:0] lower_block_size;
   logic [2:0] upper_block_size;
   modport source (output lower_block_wait_count, middle_block_wait_count,
      upper_block_wait_count, io_cycle_wait_count, dma_cycle_wait_count,
      refresh_cycle_wait_count, lower_block_size, upper_block_size);
   modport sink (input lower_block_wait_count, middle_block_wait_count,
      upper_block_wait_count, io_cycle_wait_count, dma_cycle_wait_count,
      refresh_cycle_wait_count, lower_block_size, upper_block_size);
endinterface : wait_config_if
`default_nettype wire

/* File: core/wait_count_select.sv */
`timescale 1ns/1ns
`default_nettype none
// Picks the wait count for one cycle from its kind and address
module wait_count_select #(
   parameter int ADDR_WIDTH = 20
) (
   wait_config_if.sink cfg,
   input wire logic [ADDR_WIDTH-1:0] addr_in,
   input wire wait_state_pkg::cycle_kind_t kind_in,
   output logic [1:0] wait_count_out,
   output var wait_state_pkg::block_t block_out
);
   localparam int UNITS_WIDTH = ADDR_WIDTH - wait_state_pkg::UNIT_SHIFT;
   logic [UNITS_WIDTH-1:0] addr_units;
   logic [UNITS_WIDTH-1:0] lower_units;
   logic [UNITS_WIDTH-1:0] upper_units;
   logic [UNITS_WIDTH-1:0] upper_start;

   // ==========================================================
   // Block boundaries in 32 KB units
   assign addr_units = addr_in[ADDR_WIDTH-1:wait_state_pkg::UNIT_SHIFT];
   assign lower_units = UNITS_WIDTH'(wait_state_pkg::SIZE_UNITS[cfg.lower_block_size]);
   assign upper_units = UNITS_WIDTH'(wait_state_pkg::SIZE_UNITS[cfg.upper_block_size]);
   assign upper_start = UNITS_WIDTH'(0) - upper_units;

   // Upper block checked first where the two overlap
   always_comb begin
      if (addr_units >= upper_start) begin
         block_out = wait_state_pkg::BLK_UPPER;
      end else if (addr_units < lower_units) begin
         block_out = wait_state_pkg::BLK_LOWER;
      end else begin
         block_out = wait_state_pkg::BLK_MIDDLE;
      end
   end

   // Kind decides first; address used only for memory cycles
   always_comb begin
      case (kind_in)
         wait_state_pkg::CYC_IO: wait_count_out = cfg.io_cycle_wait_count;
         wait_state_pkg::CYC_DMA: wait_count_out = cfg.dma_cycle_wait_count;
         wait_state_pkg::CYC_REFRESH: wait_count_out = cfg.refresh_cycle_wait_count;
         default: begin
            case (block_out)
               wait_state_pkg::BLK_UPPER: wait_count_out = cfg.upper_block_wait_count;
               wait_state_pkg::BLK_LOWER: wait_count_out = cfg.lower_block_wait_count;
               default: wait_count_out = cfg.middle_block_wait_count;
            endcase
         end
      endcase
   end
endmodule : wait_count_select
`default_nettype wire

/* File: core/memory_wait_state_generator.sv */
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Memory accesses classed as lower, middle or upper block; that block's waits inserted.
// - Upper block is top of space, lower block bottom, middle between.
// - Block sizes only 32,64,96,128,192,256,384 or 512 KB.
// - I/O cycles use their own programmable wait count.
// - Refresh cycles use their own programmable wait count.
// - DMA cycles use their own programmable wait count.
// - I/O, DMA and refresh counts apply regardless of address.
// - DMA and refresh cycles ignore block and I/O counts.
module memory_wait_state_generator #(
   parameter int ADDR_WIDTH = 20
) (
   // Clock and reset
   input wire logic MCLK_IN,
   input wire logic RESET_N_IN,
   // APB slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // Bus cycle sequencer
   input wire logic CYCLE_START_IN,
   input wire logic [1:0] CYCLE_KIND_IN,
   input wire logic [ADDR_WIDTH-1:0] CYCLE_ADDR_IN,
   output logic WAIT_OUT,
   output logic CYCLE_READY_OUT,
   output logic [1:0] CYCLE_BLOCK_OUT
);
   // Space must hold two 512 KB blocks; wider buses are not served
   if (ADDR_WIDTH < 20 || ADDR_WIDTH > 32) begin : g_bad_width
      $error("ADDR_WIDTH must be 20 to 32");
   end

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_WAIT = 1'b1
   } seq_state_t;

   wait_config_if cfg ();
   logic [1:0] lower_wait;
   logic [1:0] middle_wait;
   logic [1:0] upper_wait;
   logic [1:0] io_wait;
   logic [1:0] dma_wait;
   logic [1:0] refresh_wait;
   logic [2:0] lower_size;
   logic [2:0] upper_size;
   logic [1:0] sel_count;
   wait_state_pkg::block_t sel_block;
   seq_state_t state;
   logic [1:0] remaining;
   logic [1:0] last_count;
   logic access;
   logic wr;
   logic mapped;
   logic [31:0] next_rdata;
   logic read_setup;

   // ==========================================================
   // APB slave: zero wait, error on unmapped address
   assign access = PSEL_IN && PENABLE_IN;
   assign wr = access && PWRITE_IN;
   assign read_setup = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
   assign PREADY_OUT = 1'b1;
   assign mapped = (PADDR_IN == wait_state_pkg::WAIT_CYCLE_REG_ONE_ADDR)
      || (PADDR_IN == wait_state_pkg::WAIT_CYCLE_REG_TWO_ADDR)
      || (PADDR_IN == wait_state_pkg::BLOCK_BOUNDARY_REG_ADDR)
      || (PADDR_IN == wait_state_pkg::REFRESH_CONTROL_REG_ADDR)
      || (PADDR_IN == wait_state_pkg::STATUS_REG_ADDR);
   assign PSLVERR_OUT = access && !mapped;

   // Memory block waits
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         lower_wait <= wait_state_pkg::WAIT_RESET;
         middle_wait <= wait_state_pkg::WAIT_RESET;
         upper_wait <= wait_state_pkg::WAIT_RESET;
      end else if (wr && PADDR_IN == wait_state_pkg::WAIT_CYCLE_REG_ONE_ADDR) begin
         lower_wait <= PWDATA_IN[wait_state_pkg::LOWER_WAIT_POS +: wait_state_pkg::WAIT_WIDTH];
         middle_wait <= PWDATA_IN[wait_state_pkg::MIDDLE_WAIT_POS +: wait_state_pkg::WAIT_WIDTH];
         upper_wait <= PWDATA_IN[wait_state_pkg::UPPER_WAIT_POS +: wait_state_pkg::WAIT_WIDTH];
      end
   end

   // I/O and DMA waits
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         io_wait <= wait_state_pkg::WAIT_RESET;
         dma_wait <= wait_state_pkg::WAIT_RESET;
      end else if (wr && PADDR_IN == wait_state_pkg::WAIT_CYCLE_REG_TWO_ADDR) begin
         io_wait <= PWDATA_IN[wait_state_pkg::IO_WAIT_POS +: wait_state_pkg::WAIT_WIDTH];
         dma_wait <= PWDATA_IN[wait_state_pkg::DMA_WAIT_POS +: wait_state_pkg::WAIT_WIDTH];
      end
   end

   // Block sizes, codes 0..7 only
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         lower_size <= wait_state_pkg::SIZE_RESET;
         upper_size <= wait_state_pkg::SIZE_RESET;
      end else if (wr && PADDR_IN == wait_state_pkg::BLOCK_BOUNDARY_REG_ADDR) begin
         lower_size <= PWDATA_IN[wait_state_pkg::LOWER_SIZE_POS +: wait_state_pkg::SIZE_WIDTH];
         upper_size <= PWDATA_IN[wait_state_pkg::UPPER_SIZE_POS +: wait_state_pkg::SIZE_WIDTH];
      end
   end

   // Refresh wait
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         refresh_wait <= wait_state_pkg::WAIT_RESET;
      end else if (wr && PADDR_IN == wait_state_pkg::REFRESH_CONTROL_REG_ADDR) begin
         refresh_wait <= PWDATA_IN[wait_state_pkg::REFRESH_WAIT_POS +: wait_state_pkg::WAIT_WIDTH];
      end
   end

   // Read mux
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (PADDR_IN)
         wait_state_pkg::WAIT_CYCLE_REG_ONE_ADDR: begin
            next_rdata[wait_state_pkg::LOWER_WAIT_POS +: wait_state_pkg::WAIT_WIDTH] = lower_wait;
            next_rdata[wait_state_pkg::MIDDLE_WAIT_POS +: wait_state_pkg::WAIT_WIDTH] = middle_wait;
            next_rdata[wait_state_pkg::UPPER_WAIT_POS +: wait_state_pkg::WAIT_WIDTH] = upper_wait;
         end
         wait_state_pkg::WAIT_CYCLE_REG_TWO_ADDR: begin
            next_rdata[wait_state_pkg::IO_WAIT_POS +: wait_state_pkg::WAIT_WIDTH] = io_wait;
            next_rdata[wait_state_pkg::DMA_WAIT_POS +: wait_state_pkg::WAIT_WIDTH] = dma_wait;
         end
         wait_state_pkg::BLOCK_BOUNDARY_REG_ADDR: begin
            next_rdata[wait_state_pkg::LOWER_SIZE_POS +: wait_state_pkg::SIZE_WIDTH] = lower_size;
            next_rdata[wait_state_pkg::UPPER_SIZE_POS +: wait_state_pkg::SIZE_WIDTH] = upper_size;
         end
         wait_state_pkg::REFRESH_CONTROL_REG_ADDR: begin
            next_rdata[wait_state_pkg::REFRESH_WAIT_POS +: wait_state_pkg::WAIT_WIDTH] = refresh_wait;
         end
         wait_state_pkg::STATUS_REG_ADDR: begin
            next_rdata[wait_state_pkg::STATUS_COUNT_POS +: wait_state_pkg::WAIT_WIDTH] = last_count;
            next_rdata[wait_state_pkg::STATUS_BUSY_POS] = (state == ST_WAIT);
         end
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data captured in the setup cycle, so it stands through the access phase
   // Keeps the slave zero-wait while the data output still comes from a flip-flop
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         PRDATA_OUT <= 32'h0000_0000;
      end else if (read_setup) begin
         PRDATA_OUT <= next_rdata;
      end else if (!access) begin
         PRDATA_OUT <= 32'h0000_0000; // Idle bus reads zero
      end
   end

   // ==========================================================
   // Settings to classifier
   assign cfg.lower_block_wait_count = lower_wait;
   assign cfg.middle_block_wait_count = middle_wait;
   assign cfg.upper_block_wait_count = upper_wait;
   assign cfg.io_cycle_wait_count = io_wait;
   assign cfg.dma_cycle_wait_count = dma_wait;
   assign cfg.refresh_cycle_wait_count = refresh_wait;
   assign cfg.lower_block_size = lower_size;
   assign cfg.upper_block_size = upper_size;

   wait_count_select #(
      .ADDR_WIDTH(ADDR_WIDTH)
   ) u_select (
      .cfg(cfg.sink),
      .addr_in(CYCLE_ADDR_IN),
      .kind_in(wait_state_pkg::cycle_kind_t'(CYCLE_KIND_IN)),
      .wait_count_out(sel_count),
      .block_out(sel_block)
   );

   // ==========================================================
   // Wait sequencer: N cycles of WAIT_OUT after start
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         state <= ST_IDLE;
         remaining <= 2'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (CYCLE_START_IN && sel_count != 2'h0) begin
                  state <= ST_WAIT;
                  remaining <= sel_count - 2'h1;
               end
            end
            ST_WAIT: begin
               if (remaining == 2'h0) begin
                  state <= ST_IDLE;
               end else begin
                  remaining <= remaining - 2'h1;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Latched count and block of the last started cycle
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         last_count <= 2'h0;
         CYCLE_BLOCK_OUT <= 2'h0;
      end else if (CYCLE_START_IN && state == ST_IDLE) begin
         last_count <= sel_count;
         CYCLE_BLOCK_OUT <= sel_block;
      end
   end

   assign WAIT_OUT = (state == ST_WAIT);
   assign CYCLE_READY_OUT = (state == ST_IDLE);
endmodule : memory_wait_state_generator
`default_nettype wire

/* File: verif/wait_state_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Checker on the top-level ports
module wait_state_monitor #(
   parameter int ADDR_WIDTH = 20
) (
   // Clock and reset
   input wire logic MCLK_IN,
   input wire logic RESET_N_IN,
   // APB
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic PSLVERR_OUT,
   // Cycle side
   input wire logic CYCLE_START_IN,
   input wire logic [ADDR_WIDTH-1:0] CYCLE_ADDR_IN,
   input wire logic WAIT_OUT,
   input wire logic CYCLE_READY_OUT,
   input wire logic [1:0] CYCLE_BLOCK_OUT
);
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   logic [4:0] top_bits;
   // Top five address bits pick a 32 KB slice
   assign top_bits = CYCLE_ADDR_IN[ADDR_WIDTH-1 -: 5];
   // Start accepted, start refused
   sequence s_taken;
      CYCLE_START_IN && CYCLE_READY_OUT;
   endsequence
   sequence s_refused;
      CYCLE_START_IN && WAIT_OUT;
   endsequence
   a_ready_when_idle: assert property (CYCLE_READY_OUT != WAIT_OUT)
      else $error("ready and wait agree");
   a_wait_max_three: assert property ($rose(WAIT_OUT) |-> ##[1:3] !WAIT_OUT)
      else $error("wait longer than three cycles");
   a_wait_has_cause: assert property ($rose(WAIT_OUT) |-> $past(CYCLE_START_IN) && $past(CYCLE_READY_OUT))
      else $error("wait without accepted start");
   a_top_slice_upper: assert property (s_taken ##0 (top_bits == 5'h1f) |=> CYCLE_BLOCK_OUT == 2'h2)
      else $error("top slice not upper block");
   a_bottom_slice_lower: assert property (s_taken ##0 (top_bits == 5'h00) |=> CYCLE_BLOCK_OUT == 2'h0)
      else $error("bottom slice not lower block");
   a_refused_start_kept: assert property (s_refused |=> $stable(CYCLE_BLOCK_OUT))
      else $error("refused start changed block");
   a_block_holds: assert property (!CYCLE_START_IN |=> $stable(CYCLE_BLOCK_OUT))
      else $error("block changed without start");
   a_unmapped_error: assert property (PSEL_IN && PENABLE_IN && PADDR_IN > 8'h10 |-> PSLVERR_OUT)
      else $error("no error on unmapped address");
endmodule : wait_state_monitor
bind memory_wait_state_generator wait_state_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) i_wait_state_monitor (
   .MCLK_IN(MCLK_IN), .RESET_N_IN(RESET_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
   .PADDR_IN(PADDR_IN), .PSLVERR_OUT(PSLVERR_OUT), .CYCLE_START_IN(CYCLE_START_IN),
   .CYCLE_ADDR_IN(CYCLE_ADDR_IN), .WAIT_OUT(WAIT_OUT), .CYCLE_READY_OUT(CYCLE_READY_OUT),
   .CYCLE_BLOCK_OUT(CYCLE_BLOCK_OUT));
`default_nettype wire

/* File: verif/cycle_sequencer_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Bus cycle sequencer: issues cycles and counts waits
module cycle_sequencer_model (
   // Clock and status
   input wire logic clk_in,
   input wire logic wait_in,
   // Cycle request
   output logic start_out,
   output logic [1:0] kind_out,
   output logic [19:0] addr_out
);
   initial begin
      start_out = 1'b0;
      kind_out = 2'h0;
      addr_out = 20'h00000;
   end
   // One cycle; pushy holds start into the wait (refused)
   task automatic run(input logic [1:0] k, input logic [19:0] a, input logic p, output int n);
      n = 0;
      start_out <= 1'b1;
      kind_out <= k;
      addr_out <= a;
      @(posedge clk_in);
      start_out <= p;
      kind_out <= ~k; // Released lines toggle
      addr_out <= ~a;
      @(posedge clk_in);
      start_out <= 1'b0;
      while (wait_in === 1'b1 && n < 8) begin
         n++;
         @(posedge clk_in);
      end
      // Gap edge, so a next call never reassigns start in this time step
      @(posedge clk_in);
   endtask : run
endmodule : cycle_sequencer_model
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Testbench top
module tb;
   logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err, start, wait_sig, ready;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] kind, block;
   logic [19:0] addr;
   int failures = 0;
   int compares = 0;
   int units [8] = '{1, 2, 3, 4, 6, 8, 12, 16};
   int wt [3] = '{1, 2, 0};
   logic [31:0] rst_val [4] = '{32'h3f, 32'hf, 32'h77, 32'h3};
   int sz, a, blk;
   int pts [4];
   // Clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   memory_wait_state_generator i_memory_wait_state_generator (.MCLK_IN(mclk),
      .RESET_N_IN(reset_n), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
      .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .CYCLE_START_IN(start), .CYCLE_KIND_IN(kind),
      .CYCLE_ADDR_IN(addr), .WAIT_OUT(wait_sig), .CYCLE_READY_OUT(ready),
      .CYCLE_BLOCK_OUT(block));
   cycle_sequencer_model i_cycle_sequencer_model (.clk_in(mclk), .wait_in(wait_sig),
      .start_out(start), .kind_out(kind), .addr_out(addr));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("mismatch time %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task close_out;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   // APB transfer, entered just after a rising edge
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb
   // One sequencer cycle with its expected wait count
   task cyc(input logic [1:0] k, input int ad, input int en, input logic p);
      int n;
      i_cycle_sequencer_model.run(k, 20'(ad), p, n);
      chk(32'(n), 32'(en));
   endtask : cyc
   // Watchdog
   initial begin
      repeat (8000) @(posedge mclk);
      failures++;
      close_out();
   end
   // Main sequence
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      reset_n = 1'b0;
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk(rd, rst_val[i]);
      end
      cyc(wait_state_pkg::CYC_IO, 0, 3, 1'b0);
      cyc(wait_state_pkg::CYC_MEMORY, 'hfffff, 3, 1'b1);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, 8'h00, 32'h09);
      for (int c = 0; c < 8; c++) begin
         sz = units[c] << 15;
         pts = '{sz - 1, sz, 1048576 - sz - 1, 1048576 - sz};
         apb(1'b1, 8'h08, 32'(c * 17));
         for (int j = 0; j < 4; j++) begin
            a = pts[j];
            blk = (a >= 1048576 - sz) ? 2 : (a < sz) ? 0 : 1;
            cyc(wait_state_pkg::CYC_MEMORY, a, wt[blk], 1'b0);
            chk(32'(block), 32'(blk));
         end
      end
      for (int n = 0; n < 4; n++) begin
         apb(1'b1, 8'h04, 32'(n + 4 * (3 - n)));
         apb(1'b1, 8'h0c, 32'((n + 1) % 4));
         apb(1'b0, 8'h04, 32'h0);
         chk(rd, 32'(n + 4 * (3 - n)));
         cyc(wait_state_pkg::CYC_IO, 'hfffff, n, 1'b0);
         cyc(wait_state_pkg::CYC_DMA, 0, 3 - n, 1'b0);
         cyc(wait_state_pkg::CYC_REFRESH, 'h40000, (n + 1) % 4, 1'b0);
      end
      // Typical setup: zero only upper, DMA and refresh at one wait each
      apb(1'b1, 8'h00, 32'h05);
      apb(1'b1, 8'h04, 32'h05);
      apb(1'b1, 8'h0c, 32'h01);
      cyc(wait_state_pkg::CYC_MEMORY, 20'hfffff, 0, 1'b0);
      cyc(wait_state_pkg::CYC_DMA, 20'hfffff, 1, 1'b0);
      cyc(wait_state_pkg::CYC_REFRESH, 20'h00000, 1, 1'b0);
      apb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h1);
      // Reset in mid-run puts every count back to its slowest value
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, rst_val[0]);
      cyc(wait_state_pkg::CYC_DMA, 20'h00000, 3, 1'b0);
      close_out();
   end
endmodule : tb
`default_nettype wire
